// ### pkg/bdpsc_pkg.sv
// Package for the backup domain pin state control block.
// Assumes one 100 MHz clock and an active-low asynchronous reset.
package bdpsc_pkg;

  // ****************************************
  // Device states
  // ****************************************
  typedef enum logic [9:0] {
    BDPSC_POR      = 10'h001,
    BDPSC_EXT_RST  = 10'h002,
    BDPSC_INT_RST  = 10'h004,
    BDPSC_RUN      = 10'h008,
    BDPSC_LOWPWR   = 10'h010,
    BDPSC_DS_RTC   = 10'h020,
    BDPSC_DS_STOP  = 10'h040,
    BDPSC_DS_RET   = 10'h080,
    BDPSC_VBAT_RTC = 10'h100,
    BDPSC_VBAT_RET = 10'h200
  } bdpsc_state_t;

  // Code of the device state request input
  typedef enum logic [3:0] {
    BDPSC_REQ_RUN      = 4'h0,
    BDPSC_REQ_SLEEP    = 4'h1,
    BDPSC_REQ_TIMER    = 4'h2,
    BDPSC_REQ_RTC      = 4'h3,
    BDPSC_REQ_STOP     = 4'h4,
    BDPSC_REQ_DS_RTC   = 4'h5,
    BDPSC_REQ_DS_STOP  = 4'h6,
    BDPSC_REQ_DS_RET   = 4'h7,
    BDPSC_REQ_VBAT_RTC = 4'h8,
    BDPSC_REQ_VBAT_RET = 4'h9,
    BDPSC_REQ_INT_RST  = 4'hA
  } bdpsc_req_t;

  // ****************************************
  // Pin function selection
  // ****************************************
  typedef enum logic [2:0] {
    BDPSC_FN_GPIO     = 3'h0,
    BDPSC_FN_SUB_IN   = 3'h1,
    BDPSC_FN_EXT_SUB  = 3'h2,
    BDPSC_FN_OSC_OUT  = 3'h3,
    BDPSC_FN_RESOURCE = 3'h4
  } bdpsc_func_t;

  localparam int BDPSC_NPINS = 4;
  localparam logic BDPSC_STOP_CTL_HALT = 1'b1;
  localparam logic BDPSC_FORCED_IN = 1'b0;

endpackage

// ### pkg/bdpsc_pin_if.sv
// Interface carrying one pin's decided state from the main block to the pad stage.
// Assumes it is instantiated inside the top module.
`timescale 1ns/10ps
interface bdpsc_pin_if;
  logic hold;
  logic hiz;
  logic in_en;
  logic force_zero;
  logic out_val;
  logic oe_val;
  modport ctl (output hold, output hiz, output in_en, output force_zero, output out_val, output oe_val);
  modport pad (input hold, input hiz, input in_en, input force_zero, input out_val, input oe_val);
endinterface

// ### rtl/bdpsc_pad.sv
// Pad stage of one backup domain pin: holds the last driven level while asked to.
// Assumes a control interface driven on the same clock.
`timescale 1ns/10ps
module bdpsc_pad (
  input wire logic clock,
  input wire logic arst_n,
  bdpsc_pin_if.pad ctl,
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe,
  output logic core_in
);
  import bdpsc_pkg::*;

  logic out_q;
  logic oe_q;
  logic in_q;
  logic out_d;
  logic oe_d;
  logic in_d;

  // Hi-Z and forced zero override hold; held pins keep their last state unless input enabled; others follow the requested drive
  assign out_d = ctl.hold ? out_q : ctl.out_val;
  assign oe_d = ctl.hiz ? 1'b0 : (ctl.hold ? oe_q : ctl.oe_val);
  assign in_d = ctl.force_zero ? BDPSC_FORCED_IN : (ctl.in_en ? pin_i : (ctl.hold ? in_q : BDPSC_FORCED_IN));

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      out_q <= 1'b0;
      oe_q <= 1'b0;
      in_q <= 1'b0;
    end else begin
      out_q <= out_d;
      oe_q <= oe_d;
      in_q <= in_d;
    end
  end

  assign pin_o = out_q;
  assign pin_oe = oe_q;
  assign core_in = in_q;
endmodule

// ### rtl/bdpsc_top.sv
// Backup domain pin state control: picks each pin's state from device state and function.
// Assumes pin inputs, power-on and external reset are asynchronous; all other inputs come from logic on this clock.
// Function
// R1: Both supplies powering up apply power-on pin states to every backup pin.
// R2: Sub-clock input pins stay input enabled; hold in backup-only RTC and retention.
// R3: During power-on reset the oscillator output pin is high-impedance with input 0.
// R4: Low-power states hold the oscillator output pin; stopped oscillator makes it Hi-Z.
// R5: Stop-control bit 0 keeps oscillator output held and oscillation running.
// R6: Stop-control bit 1 halts oscillation on Stop or Deep Standby Stop entry.
// R7: External sub-clock pin disabled at power-on, then holds in every later state.
`timescale 1ns/10ps
module bdpsc_top #(
  parameter int NPINS = bdpsc_pkg::BDPSC_NPINS
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic por_active,
  input wire logic external_reset_n,
  input wire logic [3:0] state_req,
  input wire logic standby_pin_level_sel,
  input wire logic sub_osc_stop_ctl,
  input wire logic [3*NPINS-1:0] pin_func,
  input wire logic [NPINS-1:0] gpio_out,
  input wire logic [NPINS-1:0] gpio_oe,
  input wire logic [NPINS-1:0] pin_i,
  output logic [NPINS-1:0] pin_o,
  output logic [NPINS-1:0] pin_oe,
  output logic [NPINS-1:0] core_in,
  output logic sub_osc_run,
  output logic [9:0] dev_state
);
  import bdpsc_pkg::*;

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [NPINS-1:0] pin_s1_q;
  logic [NPINS-1:0] pin_s2_q;
  logic por_s1_q;
  logic por_s2_q;
  logic xrst_s1_q;
  logic xrst_s2_q;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      por_s1_q <= 1'b1;
      por_s2_q <= 1'b1;
      xrst_s1_q <= 1'b0;
      xrst_s2_q <= 1'b0;
    end else begin
      pin_s1_q <= pin_i;
      pin_s2_q <= pin_s1_q;
      por_s1_q <= por_active;
      por_s2_q <= por_s1_q;
      xrst_s1_q <= external_reset_n;
      xrst_s2_q <= xrst_s1_q;
    end
  end

  // ****************************************
  // Device state machine
  // ****************************************
  bdpsc_state_t state_q;
  bdpsc_state_t state_d;
  bdpsc_state_t req_state;
  bdpsc_req_t req;

  assign req = bdpsc_req_t'(state_req);

  always_comb begin
    unique case (req)
      BDPSC_REQ_RUN, BDPSC_REQ_SLEEP: req_state = BDPSC_RUN;
      BDPSC_REQ_TIMER, BDPSC_REQ_RTC, BDPSC_REQ_STOP: req_state = BDPSC_LOWPWR;
      BDPSC_REQ_DS_RTC: req_state = BDPSC_DS_RTC;
      BDPSC_REQ_DS_STOP: req_state = BDPSC_DS_STOP;
      BDPSC_REQ_DS_RET: req_state = BDPSC_DS_RET;
      BDPSC_REQ_VBAT_RTC: req_state = BDPSC_VBAT_RTC;
      BDPSC_REQ_VBAT_RET: req_state = BDPSC_VBAT_RET;
      BDPSC_REQ_INT_RST: req_state = BDPSC_INT_RST;
      default: req_state = BDPSC_RUN;
    endcase
  end

  // Power-on overrides everything, then external reset
  assign state_d = por_s2_q ? BDPSC_POR : (!xrst_s2_q ? BDPSC_EXT_RST : req_state); // see R1

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= BDPSC_POR;
    end else begin
      state_q <= state_d;
    end
  end

  assign dev_state = state_q;

  // ****************************************
  // Sub oscillator stop control
  // ****************************************
  logic stop_entry;
  logic osc_run_q;
  logic osc_run_d;

  assign stop_entry = (req == BDPSC_REQ_STOP) || (req == BDPSC_REQ_DS_STOP);
  // Halt on stop entry only when the control bit asks for it; restart outside stop
  assign osc_run_d = (stop_entry && sub_osc_stop_ctl == BDPSC_STOP_CTL_HALT) ? 1'b0 // see R6
                   : (stop_entry ? osc_run_q : 1'b1); // see R5

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      osc_run_q <= 1'b1;
    end else begin
      osc_run_q <= osc_run_d;
    end
  end

  assign sub_osc_run = osc_run_q;

  // ****************************************
  // Per-pin state decision
  // ****************************************
  logic in_por;
  logic in_vbat;
  logic in_lowpwr;

  assign in_por = (state_q == BDPSC_POR);
  assign in_vbat = (state_q == BDPSC_VBAT_RTC) || (state_q == BDPSC_VBAT_RET);
  assign in_lowpwr = (state_q == BDPSC_LOWPWR) || (state_q == BDPSC_DS_RTC) || (state_q == BDPSC_DS_STOP);

  genvar g;
  generate
    for (g = 0; g < NPINS; g++) begin : g_pin
      bdpsc_pin_if pif ();
      bdpsc_func_t fn;
      logic run_like;

      assign fn = bdpsc_func_t'(pin_func[3*g +: 3]);
      assign run_like = (state_q == BDPSC_RUN) && (fn == BDPSC_FN_GPIO || fn == BDPSC_FN_RESOURCE);

      // Sub clock input enabled everywhere but the backup-only RTC and retention states
      assign pif.in_en = (fn == BDPSC_FN_SUB_IN) && !in_vbat; // see R2
      // Power-on floats every pin; low-power with a halted oscillator floats its output
      assign pif.hiz = in_por // see R1 R3 R7
                     || (fn == BDPSC_FN_OSC_OUT && in_lowpwr && !osc_run_q); // see R4
      assign pif.force_zero = in_por && (fn == BDPSC_FN_OSC_OUT || fn == BDPSC_FN_EXT_SUB // see R3 R7
                                         || fn == BDPSC_FN_GPIO);
      // Only run state lets software drive; all other states except power-on hold
      assign pif.hold = !run_like && !in_por; // see R4 R5 R7
      assign pif.out_val = gpio_out[g];
      assign pif.oe_val = gpio_oe[g] && run_like;

      bdpsc_pad u_pad (
        .clock(clock),
        .arst_n(arst_n),
        .ctl(pif.pad),
        .pin_i(pin_s2_q[g]),
        .pin_o(pin_o[g]),
        .pin_oe(pin_oe[g]),
        .core_in(core_in[g])
      );
    end
  endgenerate

  // Level select only affects pull-ups outside this block; kept for completeness
  logic spl_unused;
  assign spl_unused = standby_pin_level_sel;

endmodule

// ### testbench/bdpsc_chk.sv
// Assertions on the top ports of the backup domain pin state control.
// Assumes pin 1 sub-clock input, pin 2 external sub clock, pin 3 oscillator output.
`timescale 1ns/10ps
module bdpsc_chk #(
  parameter int NPINS = 4
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic por_active,
  input wire logic external_reset_n,
  input wire logic [3:0] state_req,
  input wire logic sub_osc_stop_ctl,
  input wire logic [3*NPINS-1:0] pin_func,
  input wire logic [NPINS-1:0] pin_i,
  input wire logic [NPINS-1:0] pin_o,
  input wire logic [NPINS-1:0] pin_oe,
  input wire logic [NPINS-1:0] core_in,
  input wire logic sub_osc_run,
  input wire logic [9:0] dev_state
);
  import bdpsc_pkg::*;
  // ****
  // Pin state and sub oscillator checks
  // ****
  logic por_s;
  logic vbat_s;
  logic low_s;
  assign por_s = dev_state == BDPSC_POR;
  assign vbat_s = dev_state[8] | dev_state[9];
  assign low_s = dev_state == BDPSC_LOWPWR;
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  por_hiz_a: assert property (por_s [*2] |-> pin_oe == '0)
    else $error("pin driven in power-on reset");
  sub_in_a: assert property ((pin_func[5:3] == BDPSC_FN_SUB_IN && !vbat_s && $stable(pin_i[1])) [*6]
    |-> core_in[1] == pin_i[1]) else $error("sub-clock input not enabled");
  osc_por_a: assert property (por_s [*2] |-> !pin_oe[3] && core_in[3] == BDPSC_FORCED_IN)
    else $error("oscillator output pin active in power-on reset");
  osc_hiz_a: assert property (!sub_osc_run && pin_func[11:9] == BDPSC_FN_OSC_OUT |=> !pin_oe[3])
    else $error("stopped oscillator output pin not high impedance");
  osc_hold_a: assert property (dev_state == BDPSC_RUN && !sub_osc_stop_ctl ##1 (low_s && !sub_osc_stop_ctl) [*3]
    |-> sub_osc_run && $stable(pin_oe[3]) && $stable(pin_o[3]))
    else $error("oscillator output not held");
  osc_halt_a: assert property (dev_state == BDPSC_RUN && external_reset_n && !por_active && sub_osc_stop_ctl
    && state_req inside {BDPSC_REQ_STOP, BDPSC_REQ_DS_STOP} |=> !sub_osc_run)
    else $error("oscillator not halted on stop entry");
  ext_hold_a: assert property (pin_func[8:6] == BDPSC_FN_EXT_SUB && $stable(pin_func) && !por_s
    |=> $stable(pin_oe[2]) && $stable(pin_o[2])) else $error("external sub clock pin changed");
  cover property (low_s && !sub_osc_run);
  cover property (dev_state == BDPSC_VBAT_RTC);
  cover property (dev_state == BDPSC_RUN && pin_oe[0]);
endmodule
bind bdpsc_top bdpsc_chk #(.NPINS(NPINS)) chk (.clock, .arst_n, .por_active, .external_reset_n, .state_req,
  .sub_osc_stop_ctl, .pin_func, .pin_i, .pin_o, .pin_oe, .core_in, .sub_osc_run, .dev_state);

// ### testbench/bdpsc_top_tb.sv
// Self-checking bench of the backup domain pin state control top.
// Assumes pin 0 GPIO, 1 sub-clock input, 2 external sub clock, 3 oscillator output.
`timescale 1ns/10ps
module bdpsc_top_tb;
  import bdpsc_pkg::*;
  logic clock = 0;
  logic arst_n = 0;
  logic por_active = 1;
  logic external_reset_n = 1;
  logic sub_osc_stop_ctl = 0;
  logic [3:0] state_req = BDPSC_REQ_RUN;
  logic [11:0] pin_func = {BDPSC_FN_OSC_OUT, BDPSC_FN_EXT_SUB, BDPSC_FN_SUB_IN, BDPSC_FN_GPIO};
  logic [3:0] gpio_out = 4'h5;
  logic [3:0] gpio_oe = 4'hF;
  logic [3:0] pin_i = 4'hA;
  logic [3:0] pin_o, pin_oe, core_in;
  logic sub_osc_run;
  logic [9:0] dev_state;
  int miscompares = 0;
  int checks_done = 0;
  bdpsc_top uut (.clock(clock), .arst_n(arst_n), .por_active(por_active), .external_reset_n(external_reset_n),
    .state_req(state_req), .standby_pin_level_sel(1'b0), .sub_osc_stop_ctl(sub_osc_stop_ctl),
    .pin_func(pin_func), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe(pin_oe), .core_in(core_in), .sub_osc_run(sub_osc_run), .dev_state(dev_state));
  // ****
  // Helpers
  // ****
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic t_por;
    wt(8);
    chk(dev_state, BDPSC_POR);
    chk(pin_oe, 4'h0);
    chk(core_in, 4'h2);
  endtask
  task automatic t_run;
    por_active = 0;
    wt(8);
    chk(dev_state, BDPSC_RUN);
    chk({pin_oe[2], pin_oe[0], pin_o[0]}, 3'h3);
    pin_i = 4'h0;
    wt(6);
    chk(core_in[1], 1'b0);
  endtask
  task automatic t_stop(input logic ctl, input logic [3:0] req, input logic [9:0] st);
    sub_osc_stop_ctl = ctl;
    state_req = req;
    wt(1);
    chk(dev_state, st);
    chk(sub_osc_run, !ctl);
    wt(1);
    if (ctl) begin
      chk(pin_oe[3], 1'b0);
    end
    wt(3);
    state_req = BDPSC_REQ_RUN;
    wt(4);
    chk(sub_osc_run, 1'b1);
  endtask
  task automatic t_vbat;
    pin_i = 4'h2;
    wt(6);
    state_req = BDPSC_REQ_VBAT_RTC;
    wt(3);
    pin_i = 4'h0;
    wt(6);
    chk(dev_state, BDPSC_VBAT_RTC);
    chk(core_in[1], 1'b1);
    state_req = BDPSC_REQ_VBAT_RET;
    wt(6);
    chk(core_in[1], 1'b1);
    state_req = BDPSC_REQ_RUN;
    external_reset_n = 0;
    wt(8);
    chk(dev_state, BDPSC_EXT_RST);
    chk(core_in[1], 1'b0);
  endtask
  initial begin
    forever #5 clock = ~clock;
  end
  initial begin
    #20000;
    miscompares++;
    end_sim;
  end
  initial begin
    wt(4);
    arst_n = 1;
    t_por;
    t_run;
    t_stop(1'b0, BDPSC_REQ_STOP, BDPSC_LOWPWR);
    t_stop(1'b1, BDPSC_REQ_STOP, BDPSC_LOWPWR);
    t_stop(1'b1, BDPSC_REQ_DS_STOP, BDPSC_DS_STOP);
    t_vbat;
    end_sim;
  end
endmodule
